// ---- pkg/lcfs_consts.svh ----
// constants for the lcd cascade frame-sync block
`ifndef LCFS_CONSTS_SVH
`define LCFS_CONSTS_SVH
// display clock periods per frame
`define LCFS_FRAME_DIV 24
// bit width of the display tick counter
`define LCFS_TICKS_W 5
// drive-mode codes
`define LCFS_MODE_STATIC 2'h1
`define LCFS_MODE_MUX2 2'h2
`define LCFS_MODE_MUX3 2'h3
`define LCFS_MODE_MUX4 2'h0
// device-select command upper bits
`define LCFS_DEVSEL_OP 5'h1c
// last phase index per mode
`define LCFS_LAST_STATIC 2'h0
`define LCFS_LAST_MUX2 2'h1
`define LCFS_LAST_MUX3 2'h2
`define LCFS_LAST_MUX4 2'h3
// display ticks per backplane phase, so that every mode fills one frame
`define LCFS_LEN_STATIC 5'h18
`define LCFS_LEN_MUX2 5'h0c
`define LCFS_LEN_MUX3 5'h08
`define LCFS_LEN_MUX4 5'h06
`endif

// ---- pkg/lcfs_pkg.sv ----
// types shared by the lcd cascade frame-sync block
package lcfs_pkg;
    // clock role of the device in a cascade
    typedef enum logic [0:0] {
        LCFS_ROLE_SLAVE = 1'b0,
        LCFS_ROLE_MASTER = 1'b1
    } lcfs_role_t;
endpackage

// ---- pkg/lcfs_sync_if.sv ----
// carrier between phase logic and the sync pin logic
interface lcfs_sync_if;
    logic assert_req; // this device starts its last phase
    logic foreign_seen; // another device pulled the line first
    logic line_low; // synchronised line level is low
    modport phase (output assert_req, input foreign_seen, input line_low);
    modport pin (input assert_req, output foreign_seen, output line_low);
endinterface

// ---- verilog/lcfs_sync_pin.sv ----
// open-drain frame-sync pin handler with input synchroniser
module lcfs_sync_pin
    import lcfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic drive_q_out,
    lcfs_sync_if.pin sif
);
    // two-stage synchroniser; stage one feeds only stage two
    logic sync_meta_q;
    logic sync_s_q;
    logic drive_q; // holds the line low for one clock
    logic drive_d;

    // **********************************************
    // synchroniser and drive state
    // **********************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_meta_q <= 1'b1;
            sync_s_q <= 1'b1;
            drive_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_in;
            sync_s_q <= sync_meta_q;
            drive_q <= drive_d;
        end
    end

    // drive only from the start of our last phase for one clock of pull
    assign drive_d = sif.assert_req;
    assign sync_out = 1'b0;
    assign sync_oe = drive_q;
    assign drive_q_out = drive_q;
    assign sif.line_low = ~sync_s_q;
    assign sif.foreign_seen = ~sync_s_q & ~drive_q & ~sif.assert_req;
endmodule

// ---- verilog/lcfs_frame_sync.sv ----
// frame timing and cascade sync of the lcd segment driver
// Summary of operation
// - frame rate is display clock over 24
// - device number is slave bit times 8 plus subaddress
// - slaves run from the master's clock
// - aligned timing after power-on reset
// - sync pin open-drain with pull-up
// - assert sync at last active phase start
// - resync to first device asserting sync, except in static mode
// - drive mode sets number of backplanes
// - device-select loads subaddress counter low bits
`include "lcfs_consts.svh"
module lcfs_frame_sync
    import lcfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic role_master,
    input wire logic osc_internal,
    input wire logic frame_rate_select,
    input wire logic int_osc_tick,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    input wire logic slave_addr_low_bit,
    input wire logic subaddr_pin_0,
    input wire logic subaddr_pin_1,
    input wire logic subaddr_pin_2,
    input wire logic [1:0] drive_mode,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic [3:0] device_number,
    output logic device_selected,
    output logic [2:0] subaddr_count,
    output logic [1:0] bp_phase,
    output logic [3:0] backplane_active,
    output logic frame_start,
    output logic frame_rate_select_q
);
    lcfs_sync_if sif ();

    // **********************************************
    // pin synchronisers
    // **********************************************
    logic [6:0] pin_meta_q; // first stage, read only by stage two
    logic [6:0] pin_s_q;
    logic clk_div_q; // master's outgoing display clock level
    logic clk_prev_q; // previous synchronised clock level
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= 7'h00;
            pin_s_q <= 7'h00;
        end else begin
            pin_meta_q <= {clk_pin_in, frame_rate_select, slave_addr_low_bit,
                           subaddr_pin_2, subaddr_pin_1, subaddr_pin_0, osc_internal};
            pin_s_q <= pin_meta_q;
        end
    end
    wire osc_int_s = pin_s_q[0];
    wire [2:0] subaddr_s = pin_s_q[3:1];
    wire sa_s = pin_s_q[4];
    wire ff_s = pin_s_q[5];
    wire clk_pin_s = pin_s_q[6];

    // **********************************************
    // display clock source
    // **********************************************
    lcfs_role_t role;
    assign role = role_master ? LCFS_ROLE_MASTER : LCFS_ROLE_SLAVE;
    wire use_pin_clk = (role == LCFS_ROLE_SLAVE) | ~osc_int_s;
    wire pin_edge = clk_pin_s & ~clk_prev_q;
    wire master_out = (role == LCFS_ROLE_MASTER) & osc_int_s;
    wire disp_tick = use_pin_clk ? pin_edge : int_osc_tick;
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_prev_q <= 1'b0;
            clk_div_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_pin_s;
            if (master_out && int_osc_tick) begin
                clk_div_q <= ~clk_div_q;
            end
        end
    end
    assign clk_pin_out = clk_div_q;
    assign clk_pin_oe = master_out;

    // **********************************************
    // frame divider and backplane phase
    // **********************************************
    logic [4:0] tick_q; // display ticks within the phase
    logic [4:0] tick_d;
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic [1:0] last_phase;
    assign last_phase = (drive_mode == `LCFS_MODE_STATIC) ? `LCFS_LAST_STATIC :
                        (drive_mode == `LCFS_MODE_MUX2) ? `LCFS_LAST_MUX2 :
                        (drive_mode == `LCFS_MODE_MUX3) ? `LCFS_LAST_MUX3 :
                        `LCFS_LAST_MUX4;
    // phase length so that all phases fill 24 ticks
    logic [4:0] phase_len;
    assign phase_len = (drive_mode == `LCFS_MODE_STATIC) ? `LCFS_LEN_STATIC :
                       (drive_mode == `LCFS_MODE_MUX2) ? `LCFS_LEN_MUX2 :
                       (drive_mode == `LCFS_MODE_MUX3) ? `LCFS_LEN_MUX3 :
                       `LCFS_LEN_MUX4;
    localparam logic [4:0] FRAME_LAST = 5'(`LCFS_FRAME_DIV - 1);
    wire phase_end = disp_tick && (tick_q == phase_len - 5'd1);
    wire frame_end = phase_end && (phase_q == last_phase);
    wire entering_last = phase_end && (phase_q + 2'd1 == last_phase);
    always_comb begin
        tick_d = tick_q;
        phase_d = phase_q;
        if (sif.foreign_seen && phase_q != last_phase) begin
            tick_d = 5'd0;
            phase_d = last_phase;
        end else if (frame_end) begin
            tick_d = 5'd0;
            phase_d = 2'd0;
        end else if (phase_end) begin
            tick_d = 5'd0;
            phase_d = phase_q + 2'd1;
        end else if (disp_tick) begin
            tick_d = (tick_q == FRAME_LAST) ? 5'd0 : tick_q + 5'd1;
        end
    end
    // reset gives all devices phase zero
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_q <= 5'd0;
            phase_q <= 2'd0;
        end else begin
            tick_q <= tick_d;
            phase_q <= phase_d;
        end
    end
    // assert at onset of last phase
    assign sif.assert_req = entering_last ||
                            (frame_end && last_phase == `LCFS_LAST_STATIC);

    lcfs_sync_pin u_pin (
        .clk(clk),
        .reset(reset),
        .sync_in(sync_in),
        .sync_out(sync_out),
        .sync_oe(sync_oe),
        .drive_q_out(),
        .sif(sif)
    );

    // **********************************************
    // addressing and outputs
    // **********************************************
    logic [2:0] subcnt_q;
    logic [3:0] devnum_q;
    logic [1:0] phase_out_q;
    logic frame_start_q;
    logic ff_q;
    wire devsel_hit = cmd_valid && (cmd_byte[7:3] == `LCFS_DEVSEL_OP);
    always_ff @(posedge clk) begin
        if (reset) begin
            subcnt_q <= 3'h0;
            devnum_q <= 4'h0;
            phase_out_q <= 2'h0;
            frame_start_q <= 1'b0;
            ff_q <= 1'b0;
        end else begin
            if (devsel_hit) begin
                subcnt_q <= cmd_byte[2:0];
            end
            // slave bit times eight plus subaddress
            devnum_q <= {sa_s, subaddr_s};
            phase_out_q <= phase_d;
            frame_start_q <= frame_end;
            ff_q <= ff_s;
        end
    end
    assign device_number = devnum_q;
    assign subaddr_count = subcnt_q;
    assign device_selected = (subcnt_q == devnum_q[2:0]);
    assign bp_phase = phase_out_q;
    assign backplane_active = 4'h1 << phase_out_q;
    assign frame_start = frame_start_q;
    assign frame_rate_select_q = ff_q;
endmodule

// ---- tb/lcfs_properties.sv ----
// port assertions for the lcd cascade frame-sync block
module lcfs_properties
    import lcfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic role_master,
    input wire logic slave_addr_low_bit,
    input wire logic subaddr_pin_0,
    input wire logic subaddr_pin_1,
    input wire logic subaddr_pin_2,
    input wire logic [1:0] drive_mode,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic clk_pin_oe,
    input wire logic sync_out,
    input wire logic sync_oe,
    input wire logic [3:0] device_number,
    input wire logic device_selected,
    input wire logic [2:0] subaddr_count,
    input wire logic [1:0] bp_phase,
    input wire logic [3:0] backplane_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // address pins gathered; slave bit is the top bit
    wire logic [3:0] pins = {slave_addr_low_bit, subaddr_pin_2, subaddr_pin_1, subaddr_pin_0};
    // cycles since reset, so the pin synchroniser has filled before we judge it
    logic [2:0] up_q;
    always_ff @(posedge clk) up_q <= reset ? 3'h0 : up_q + 3'(~&up_q);
    dev_number_a: assert property (
        $stable(pins)[*4] ##0 &up_q |=> device_number == $past(pins))
        else $error("device number does not follow pins");
    dev_select_a: assert property (
        device_selected == (subaddr_count == device_number[2:0]))
        else $error("device select wrong");
    devsel_load_a: assert property (
        cmd_valid && cmd_byte[7:3] == 5'h1c |=> subaddr_count == $past(cmd_byte[2:0]))
        else $error("subaddress not loaded");
    other_cmd_a: assert property (
        cmd_valid && cmd_byte[7:3] != 5'h1c |=> $stable(subaddr_count))
        else $error("subaddress changed by other command");
    sync_pulse_a: assert property ($rose(sync_oe) |=> !sync_oe)
        else $error("sync pull too long");
    sync_phase_a: assert property (
        sync_oe && $stable(drive_mode) |-> bp_phase == drive_mode - 2'h1)
        else $error("sync pulled outside last phase");
    open_drain_a: assert property (sync_out == 1'b0)
        else $error("sync driven high");
    bp_onehot_a: assert property (backplane_active == 4'h1 << bp_phase)
        else $error("backplane select wrong");
    clk_master_a: assert property (clk_pin_oe |-> role_master)
        else $error("slave drives clock");
    reset_align_a: assert property ($fell(reset) |-> bp_phase == 2'h0 && !sync_oe)
        else $error("phase not aligned after reset");
endmodule
bind lcfs_frame_sync lcfs_properties lcfs_properties_inst (.*);

// ---- tb/lcfs_partner.sv ----
// a second cascaded driver, slave on the shared display clock, sharing the sync line
module lcfs_partner (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic enable,
    output logic pull_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // tick count within a frame; starts seven ticks off to model drift
    logic [4:0] count_q;
    // runs from the master tick, 24 ticks a frame
    // held seven ticks ahead while disabled, so the drift is known when it starts
    always_ff @(posedge clk) begin
        if (reset || !enable) begin
            count_q <= 5'h07;
        end else if (tick) begin
            count_q <= (count_q == 5'h17) ? 5'h00 : count_q + 5'h01;
        end
    end
    // one-clock open-drain pull as its fourth phase begins
    always_ff @(posedge clk) begin
        if (reset) begin
            pull_oe <= 1'b0;
        end else begin
            pull_oe <= enable && tick && count_q == 5'h11;
        end
    end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the lcd cascade frame-sync block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, role_master = 1, osc_internal = 1, clk_pin_in = 0;
    logic frame_rate_select = 0, int_osc_tick = 0, slave_addr_low_bit = 0, cmd_valid = 0;
    logic subaddr_pin_0 = 0, subaddr_pin_1 = 0, subaddr_pin_2 = 0, partner_en = 0;
    logic [1:0] drive_mode = 2'h0;
    logic [7:0] cmd_byte = 8'h00;
    logic [1:0] bp_phase, tcnt = 2'h0;
    logic [2:0] subaddr_count;
    logic [3:0] device_number, backplane_active;
    logic clk_pin_out, clk_pin_oe, sync_out, sync_oe, device_selected, frame_start;
    logic frame_rate_select_q, pull_oe;
    int mismatches = 0, check_count = 0;
    // wire pulled up, low while either party pulls
    wire logic sync_in = ~(sync_oe | pull_oe);
    lcfs_frame_sync lcfs_frame_sync_inst (.*);
    lcfs_partner lcfs_partner_inst (.clk(clk), .reset(reset), .tick(int_osc_tick),
        .enable(partner_en), .pull_oe(pull_oe));
    always #5 clk = ~clk;
    // display tick every fourth clock; it feeds the block's oscillator input, its clock pin model and the partner
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        int_osc_tick <= #1 (tcnt == 2'h3);
        // the master's clock as a slave sees it on its pin: one rise per tick
        clk_pin_in <= #1 (tcnt == 2'h3);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk) #1 cmd_valid = 1;
        cmd_byte = b;
        @(posedge clk) #1 cmd_valid = 0;
    endtask
    // every pin combination gives its own device number
    task automatic t_address();
        for (int n = 0; n < 16; n++) begin
            @(posedge clk) #1 {slave_addr_low_bit, subaddr_pin_2, subaddr_pin_1, subaddr_pin_0} = 4'(n);
            frame_rate_select = n[0];
            repeat (6) @(posedge clk);
            #1 check(8'(device_number), 8'(n));
            check(8'(frame_rate_select_q), 8'(n[0]));
        end
    endtask
    // device-select loads the counter, other commands leave it
    task automatic t_devsel();
        send(8'he5);
        check(8'(subaddr_count), 8'h05);
        check(8'(device_selected), 8'h00);
        send(8'he7);
        send(8'hc2);
        check(8'(subaddr_count), 8'h07);
        check(8'(device_selected), 8'h01);
    endtask
    // one frame counted in ticks and sync pulls, after waiting out two frame starts to settle
    task automatic t_frame(input logic [1:0] mode);
        int ticks, pulls, flips, n;
        logic last_clk;
        ticks = 0;
        pulls = 0;
        flips = 0;
        n = 0;
        @(posedge clk) #1 drive_mode = mode;
        repeat (2) begin
            do @(negedge clk); while (frame_start !== 1'b1 && ++n < 600);
        end
        last_clk = clk_pin_out;
        do begin
            @(negedge clk);
            ticks += int_osc_tick;
            pulls += sync_oe;
            flips += (clk_pin_out !== last_clk);
            last_clk = clk_pin_out;
        end while (frame_start !== 1'b1 && ++n < 900);
        check(8'(ticks), 8'h18);
        check(8'(pulls), 8'h01);
        check(8'(flips), role_master ? 8'h18 : 8'h00);
        check(8'(clk_pin_oe), 8'(role_master));
    endtask
    // a drifted partner pulls first and the block falls into step
    task automatic t_resync();
        int n;
        n = 0;
        @(posedge clk) #1 drive_mode = 2'h0;
        // settle, then start the partner seven ticks ahead of the block's frame
        repeat (2) begin
            do @(negedge clk); while (frame_start !== 1'b1 && ++n < 600);
        end
        @(posedge clk) #1 partner_en = 1;
        do @(negedge clk); while (pull_oe !== 1'b1 && ++n < 900);
        repeat (4) @(negedge clk);
        check(8'(bp_phase), 8'h03);
        do @(negedge clk); while (frame_start !== 1'b1 && ++n < 1200);
        check(8'(lcfs_partner_inst.count_q), 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 reset = 0;
        t_address();
        t_devsel();
        for (int m = 0; m < 4; m++) t_frame(2'(m));
        // as a slave the block runs from the clock pin and leaves it undriven
        @(posedge clk) #1 role_master = 0;
        t_frame(2'h0);
        @(posedge clk) #1 role_master = 1;
        t_resync();
        results();
    end
    // cut a hang short well past the expected run
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule
